// file: hw/sse_pkg.sv
package sse_pkg;

  // bus layout
  localparam int          AXI_AW      = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [7:0]  OFS_INSTR   = 8'h00;
  localparam logic [7:0]  OFS_WORK    = 8'h04;
  localparam logic [7:0]  OFS_STATUS  = 8'h08;
  localparam logic [7:0]  OFS_FADDR   = 8'h0C;
  localparam logic [7:0]  OFS_FDATA   = 8'h10;
  localparam logic [7:0]  OFS_WDT     = 8'h14;

  // status field positions
  localparam int          ST_C_BIT    = 0;
  localparam int          ST_DC_BIT   = 1;
  localparam int          ST_Z_BIT    = 2;
  localparam int          ST_OV_BIT   = 3;
  localparam int          ST_PD_BIT   = 4;
  localparam int          ST_TO_BIT   = 5;
  localparam int          ST_SLP_BIT  = 6;
  localparam int          ST_BUSY_BIT = 7;
  localparam int          WAKE_BIT    = 0;

  // opcode patterns
  localparam logic [6:0]  SET_OP_TOP  = 7'h15;
  localparam logic [15:0] SLEEP_WORD  = 16'h0003;
  localparam logic [3:0]  SUB_OP_TOP  = 4'hB;
  localparam logic [3:0]  SUB_OP_LOW  = 4'h0;

  // values
  localparam logic [7:0]  ALL_ONES    = 8'hFF;
  localparam logic [7:0]  WDT_CLEAR   = 8'h00;
  localparam logic [7:0]  POST_CLEAR  = 8'h00;
  localparam logic [7:0]  WDT_LAST    = 8'hFF;
  localparam logic [7:0]  POST_LAST   = 8'hFF;
  localparam logic [7:0]  WORK_RST    = 8'h00;
  localparam logic [15:0] INSTR_RST   = 16'h0000;
  localparam logic        PD_RST      = 1'b1;
  localparam logic        TO_RST      = 1'b1;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'h0,
    PH_Q1    = 3'h1,
    PH_Q2    = 3'h3,
    PH_Q3    = 3'h2,
    PH_Q4    = 3'h6,
    PH_SLEEP = 3'h7
  } sse_phase_t;

  typedef struct packed {
    logic       set_all;
    logic       keep_w;
    logic       sleep;
    logic       sub;
    logic [7:0] operand;
  } sse_dec_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic dc;
    logic c;
  } sse_flags_t;

endpackage : sse_pkg

// file: hw/sse_decode.sv
`timescale 1ns/1ps
`default_nettype none
module sse_decode #(
  parameter logic [3:0] SUB_LOW = sse_pkg::SUB_OP_LOW
) (
  input  wire logic [15:0]      word,
  output var  sse_pkg::sse_dec_t dec
);

  assign dec.set_all = (word[15:9] == sse_pkg::SET_OP_TOP);
  assign dec.keep_w  = word[8];
  assign dec.sleep   = (word == sse_pkg::SLEEP_WORD);
  assign dec.sub     = (word[15:12] == sse_pkg::SUB_OP_TOP)
                     && (word[11:8] == SUB_LOW);
  assign dec.operand = word[7:0];

endmodule : sse_decode
`default_nettype wire

// file: hw/sse_sub_alu.sv
`timescale 1ns/1ps
`default_nettype none
module sse_sub_alu (
  input  wire logic [7:0]          lit,
  input  wire logic [7:0]          work,
  output var  logic [7:0]          diff,
  output var  sse_pkg::sse_flags_t flags
);

  logic [8:0] full;
  logic [4:0] low;

  // two's complement: lit + ~work + 1
  assign full     = {1'b0, lit} + {1'b0, ~work} + 9'h001;
  assign low      = {1'b0, lit[3:0]} + {1'b0, ~work[3:0]} + 5'h01;
  assign diff     = full[7:0];
  assign flags.c  = full[8];
  assign flags.dc = low[4];
  assign flags.z  = (full[7:0] == 8'h00);
  assign flags.ov = (lit[7] ^ work[7]) & (full[7] ^ lit[7]);

endmodule : sse_sub_alu
`default_nettype wire

// file: hw/sse_exec.sv
`timescale 1ns/1ps
`default_nettype none
module sse_exec #(
  parameter logic [7:0] POST_LIMIT = sse_pkg::POST_LAST,
  parameter logic [7:0] WDT_LIMIT  = sse_pkg::WDT_LAST,
  parameter logic [3:0] SUB_LOW    = sse_pkg::SUB_OP_LOW
) (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic [sse_pkg::AXI_AW-1:0] s_awaddr,
  input  wire logic                      s_awvalid,
  output var  logic                      s_awready,
  input  wire logic [31:0]               s_wdata,
  input  wire logic [3:0]                s_wstrb,
  input  wire logic                      s_wvalid,
  output var  logic                      s_wready,
  output var  logic [1:0]                s_bresp,
  output var  logic                      s_bvalid,
  input  wire logic                      s_bready,
  input  wire logic [sse_pkg::AXI_AW-1:0] s_araddr,
  input  wire logic                      s_arvalid,
  output var  logic                      s_arready,
  output var  logic [31:0]               s_rdata,
  output var  logic [1:0]                s_rresp,
  output var  logic                      s_rvalid,
  input  wire logic                      s_rready,
  output var  logic                      osc_run,
  output var  logic                      core_asleep
);

  // core state
  sse_pkg::sse_phase_t phase;
  sse_pkg::sse_phase_t next_phase;
  sse_pkg::sse_dec_t   dec;
  sse_pkg::sse_flags_t flags;
  sse_pkg::sse_flags_t sub_flags;
  sse_pkg::sse_flags_t flags_q;
  logic [15:0]         instr_word;
  logic [7:0]          working_register;
  logic [7:0]          file_addr;
  logic [7:0]          file_mem [0:255];
  logic [7:0]          op_data;
  logic [7:0]          res_q;
  logic [7:0]          sub_diff;
  logic                power_down_flag;
  logic                watchdog_expired_flag;
  logic [7:0]          wdt_count;
  logic [7:0]          wdt_post;

  // bus state
  logic                aw_full;
  logic                w_full;
  logic [7:0]          aw_addr_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;

  // phase helpers
  wire logic idle      = (phase == sse_pkg::PH_IDLE);
  wire logic asleep    = (phase == sse_pkg::PH_SLEEP);
  wire logic busy      = !idle && !asleep;
  wire logic in_q2     = (phase == sse_pkg::PH_Q2);
  wire logic in_q3     = (phase == sse_pkg::PH_Q3);
  wire logic in_q4     = (phase == sse_pkg::PH_Q4);
  wire logic sleep_q4  = in_q4 && dec.sleep;
  wire logic set_q4    = in_q4 && dec.set_all;
  wire logic sub_q4    = in_q4 && dec.sub;
  wire logic w_from_op = sub_q4 || (set_q4 && !dec.keep_w);

  // write channel decode
  wire logic       aw_fire  = s_awvalid && s_awready;
  wire logic       w_fire   = s_wvalid && s_wready;
  wire logic       wr_go    = (aw_full || aw_fire) && (w_full || w_fire) && !s_bvalid;
  wire logic [7:0] wr_addr  = aw_full ? aw_addr_q : s_awaddr;
  wire logic [31:0] wr_data = w_full ? w_data_q : s_wdata;
  wire logic [3:0] wr_strb  = w_full ? w_strb_q : s_wstrb;
  wire logic       sel_ins  = (wr_addr == sse_pkg::OFS_INSTR);
  wire logic       sel_wrk  = (wr_addr == sse_pkg::OFS_WORK);
  wire logic       sel_sts  = (wr_addr == sse_pkg::OFS_STATUS);
  wire logic       sel_fad  = (wr_addr == sse_pkg::OFS_FADDR);
  wire logic       sel_fdt  = (wr_addr == sse_pkg::OFS_FDATA);
  wire logic       sel_wdt  = (wr_addr == sse_pkg::OFS_WDT);
  wire logic       wr_ok    = (sel_ins && idle) || (sel_wrk && !busy) || sel_sts
                            || sel_fad || (sel_fdt && !busy) || sel_wdt;
  wire logic       lane0    = wr_strb[0];
  wire logic       launch   = wr_go && sel_ins && idle && (wr_strb[1:0] == 2'b11);
  wire logic       sw_w_we  = wr_go && sel_wrk && !busy && lane0;
  wire logic       sw_a_we  = wr_go && sel_fad && lane0;
  wire logic       sw_d_we  = wr_go && sel_fdt && !busy && lane0;
  wire logic       wake_req = wr_go && sel_wdt && lane0 && wr_data[sse_pkg::WAKE_BIT];

  // read channel decode
  wire logic        ar_fire  = s_arvalid && s_arready;
  wire logic [7:0]  st_byte  = {busy, asleep, watchdog_expired_flag, power_down_flag, flags};
  wire logic        rd_ok    = (s_araddr == sse_pkg::OFS_INSTR) || (s_araddr == sse_pkg::OFS_WORK)
                             || (s_araddr == sse_pkg::OFS_STATUS) || (s_araddr == sse_pkg::OFS_FADDR)
                             || (s_araddr == sse_pkg::OFS_FDATA) || (s_araddr == sse_pkg::OFS_WDT);
  wire logic [31:0] rd_mux   =
      (s_araddr == sse_pkg::OFS_INSTR)  ? {16'h0000, instr_word} :
      (s_araddr == sse_pkg::OFS_WORK)   ? {24'h000000, working_register} :
      (s_araddr == sse_pkg::OFS_STATUS) ? {24'h000000, st_byte} :
      (s_araddr == sse_pkg::OFS_FADDR)  ? {24'h000000, file_addr} :
      (s_araddr == sse_pkg::OFS_FDATA)  ? {24'h000000, file_mem[file_addr]} :
      (s_araddr == sse_pkg::OFS_WDT)    ? {16'h0000, wdt_post, wdt_count} :
                                          32'h00000000;

  // watchdog timing
  wire logic wdt_tick   = (wdt_post == POST_LIMIT);
  wire logic wdt_expire = wdt_tick && (wdt_count == WDT_LIMIT) && !sleep_q4;

  // file memory port, instruction has priority while busy
  wire logic       mem_we    = set_q4 || sw_d_we;
  wire logic [7:0] mem_waddr = set_q4 ? dec.operand : file_addr;
  wire logic [7:0] mem_wdata = set_q4 ? res_q : wr_data[7:0];

  assign s_awready   = !aw_full && !s_bvalid;
  assign s_wready    = !w_full && !s_bvalid;
  assign s_arready   = !s_rvalid;
  assign osc_run     = !asleep;
  assign core_asleep = asleep;

  sse_decode #(
    .SUB_LOW (SUB_LOW)
  ) u_decode (
    .word (instr_word),
    .dec  (dec)
  );

  sse_sub_alu u_alu (
    .lit   (op_data),
    .work  (working_register),
    .diff  (sub_diff),
    .flags (sub_flags)
  );

  // four phases per instruction, sleep entered from the last
  always_comb begin
    case (phase)
      sse_pkg::PH_IDLE:  next_phase = launch ? sse_pkg::PH_Q1 : sse_pkg::PH_IDLE;
      sse_pkg::PH_Q1:    next_phase = sse_pkg::PH_Q2;
      sse_pkg::PH_Q2:    next_phase = sse_pkg::PH_Q3;
      sse_pkg::PH_Q3:    next_phase = sse_pkg::PH_Q4;
      sse_pkg::PH_Q4:    next_phase = dec.sleep ? sse_pkg::PH_SLEEP : sse_pkg::PH_IDLE;
      sse_pkg::PH_SLEEP: next_phase = (wake_req || wdt_expire) ? sse_pkg::PH_IDLE
                                                               : sse_pkg::PH_SLEEP;
      default:           next_phase = sse_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= sse_pkg::PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      instr_word <= sse_pkg::INSTR_RST;
    end else if (launch) begin
      instr_word <= wr_data[15:0];
    end
  end

  // Q2 operand read, Q3 process
  always_ff @(posedge clock) begin
    if (rst) begin
      op_data <= 8'h00;
      res_q   <= 8'h00;
      flags_q <= '0;
    end else begin
      if (in_q2) begin
        op_data <= dec.sub ? dec.operand : file_mem[dec.operand];
      end
      if (in_q3) begin
        res_q   <= dec.set_all ? sse_pkg::ALL_ONES : sub_diff;
        flags_q <= sub_flags;
      end
    end
  end

  // Q4 write-back of W
  always_ff @(posedge clock) begin
    if (rst) begin
      working_register <= sse_pkg::WORK_RST;
    end else if (w_from_op) begin
      working_register <= res_q;
    end else if (sw_w_we) begin
      working_register <= wr_data[7:0];
    end
  end

  // arithmetic flags only from literal-subtract
  always_ff @(posedge clock) begin
    if (rst) begin
      flags <= '0;
    end else if (sub_q4) begin
      flags <= flags_q;
    end
  end

  always_ff @(posedge clock) begin
    if (mem_we) begin
      file_mem[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      file_addr <= 8'h00;
    end else if (sw_a_we) begin
      file_addr <= wr_data[7:0];
    end
  end

  // power status flags
  always_ff @(posedge clock) begin
    if (rst) begin
      power_down_flag       <= sse_pkg::PD_RST;
      watchdog_expired_flag <= sse_pkg::TO_RST;
    end else if (sleep_q4) begin
      power_down_flag       <= 1'b0;
      watchdog_expired_flag <= 1'b1;
    end else if (wdt_expire) begin
      watchdog_expired_flag <= 1'b0;
    end
  end

  // watchdog counter with postscaler, runs in sleep as well
  always_ff @(posedge clock) begin
    if (rst || sleep_q4) begin
      wdt_post  <= sse_pkg::POST_CLEAR;
      wdt_count <= sse_pkg::WDT_CLEAR;
    end else if (wdt_tick) begin
      wdt_post  <= sse_pkg::POST_CLEAR;
      wdt_count <= (wdt_count == WDT_LIMIT) ? sse_pkg::WDT_CLEAR : wdt_count + 8'h01;
    end else begin
      wdt_post  <= wdt_post + 8'h01;
    end
  end

  // write address and data held until both present
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_full  <= 1'b0;
      w_full   <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp  <= sse_pkg::RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_full  <= 1'b0;
        w_full   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? sse_pkg::RESP_OKAY : sse_pkg::RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_full <= 1'b1;
        end
        if (w_fire) begin
          w_full <= 1'b1;
        end
        if (s_bvalid && s_bready) begin
          s_bvalid <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (aw_fire) begin
      aw_addr_q <= s_awaddr;
    end
    if (w_fire) begin
      w_data_q <= s_wdata;
      w_strb_q <= s_wstrb;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h00000000;
      s_rresp  <= sse_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_mux;
      s_rresp  <= rd_ok ? sse_pkg::RESP_OKAY : sse_pkg::RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule : sse_exec
`default_nettype wire

// file: tb/sse_exec_props.sv
`timescale 1ns/1ps
`default_nettype none
module sse_exec_props #(
  parameter logic [7:0] POST_LIMIT = sse_pkg::POST_LAST,
  parameter logic [7:0] WDT_LIMIT  = sse_pkg::WDT_LAST
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  s_awaddr,
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0]  s_wstrb,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0]  s_rresp,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic        osc_run,
  input wire logic        core_asleep
);
  localparam int SLP_MAX = (int'(POST_LIMIT) + 1) * (int'(WDT_LIMIT) + 1) + 2;
  logic [2:0]  busy_n;
  logic [16:0] slp_n;
  wire take  = s_awvalid && s_awready && s_wvalid && s_wready;
  wire instr = take && s_awaddr == sse_pkg::OFS_INSTR;
  wire idle  = busy_n == 3'h0 && !core_asleep;
  wire go    = instr && idle && s_wstrb[1:0] == 2'h3;
  wire go_sl = go && s_wdata[15:0] == 16'h0003;
  wire wake  = take && s_awaddr == sse_pkg::OFS_WDT && s_wdata[0] && s_wstrb[0];

  // four-phase shadow of the core, and time spent asleep
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_n <= 3'h0;
      slp_n  <= 17'h00000;
    end else begin
      busy_n <= go ? 3'h4 : (busy_n != 3'h0 ? busy_n - 3'h1 : 3'h0);
      slp_n  <= core_asleep ? slp_n + 17'h00001 : 17'h00000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_sleep_entry: assert property (go_sl |=> !core_asleep [*4] ##1 core_asleep)
    else $error("sleep not entered at end of fourth phase");
  a_sleep_cause: assert property ($rose(core_asleep) |-> $past(go_sl, 5))
    else $error("sleep entered without sleep word");
  a_osc_stop: assert property (go_sl |=> osc_run [*4] ##1 !osc_run)
    else $error("oscillator not stopped at end of fourth phase");
  a_wdt_wake: assert property (slp_n <= SLP_MAX)
    else $error("watchdog did not wake the core");
  a_busy_refuse: assert property (instr && !idle |=> s_bresp == sse_pkg::RESP_SLVERR)
    else $error("instruction accepted while not idle");
  a_soft_wake: assert property (wake && core_asleep |=> !core_asleep)
    else $error("wake write ignored");
  a_write_answer: assert property (take |=> s_bvalid && !s_awready && !s_wready)
    else $error("write response missing");
  a_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready)
    else $error("read response missing");
  a_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  a_slverr_zero: assert property (s_rvalid && s_rresp != 2'h0 |-> s_rdata == 32'h00000000)
    else $error("error read with data");

  c_sleep: cover property (go_sl);
  c_wake: cover property (core_asleep && !wake ##1 !core_asleep);
  c_refuse: cover property (instr && !idle);
endmodule : sse_exec_props

bind sse_exec sse_exec_props #(.POST_LIMIT(POST_LIMIT), .WDT_LIMIT(WDT_LIMIT)) i_props (
  .clock, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
  .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rdata,
  .s_rresp, .s_rvalid, .s_rready, .osc_run, .core_asleep
);
`default_nettype wire

// file: tb/sse_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module sse_exec_tb;
  logic        clock;
  logic        rst;
  logic [7:0]  s_awaddr;
  logic [7:0]  s_araddr;
  logic [31:0] s_wdata;
  logic [31:0] s_rdata;
  logic [31:0] rd;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp;
  logic [1:0]  s_rresp;
  logic [1:0]  rs;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready, osc_run, core_asleep;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;

  sse_exec #(.POST_LIMIT(8'h0F), .WDT_LIMIT(8'h03)) i_dut (
    .clock, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .osc_run, .core_asleep
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge clock);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge clock);
      if (s_awvalid && s_awready) begin
        aw_d = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_d = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!s_bvalid);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clock); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge clock); while (!s_rvalid);
    rd = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask : rdr

  task automatic expect_rd(input string n, input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    `CHK(n, e, rd)
    `CHK(n, sse_pkg::RESP_OKAY, rs)
  endtask : expect_rd

  // poll status until the busy bit clears
  task automatic wait_idle();
    rdr(sse_pkg::OFS_STATUS);
    for (int i = 0; i < 20 && rd[7]; i++) rdr(sse_pkg::OFS_STATUS);
  endtask : wait_idle

  task automatic run(input logic [15:0] w);
    wr(sse_pkg::OFS_INSTR, {16'h0000, w});
    wait_idle();
  endtask : run

  task automatic t_busy();
    wr(sse_pkg::OFS_WORK, 32'h00000001);
    wr(sse_pkg::OFS_INSTR, {16'h0000, 4'hB, sse_pkg::SUB_OP_LOW, 8'h05});
    wr(sse_pkg::OFS_INSTR, 32'h00000003);
    `CHK("second launch", sse_pkg::RESP_SLVERR, rs)
    wait_idle();
    `CHK("asleep after refused", 1'b0, rd[6])
    expect_rd("first difference", sse_pkg::OFS_WORK, 32'h00000004);
  endtask : t_busy

  task automatic t_sub();
    logic [7:0] k[4];
    logic [7:0] w[4];
    logic [7:0] r[4];
    logic [3:0] f[4];
    k = '{8'h02, 8'h02, 8'h02, 8'h80};
    w = '{8'h01, 8'h02, 8'h03, 8'h01};
    r = '{8'h01, 8'h00, 8'hFF, 8'h7F};
    f = '{4'h3, 4'h7, 4'h0, 4'h9};
    for (int i = 0; i < 4; i++) begin
      wr(sse_pkg::OFS_WORK, {24'h000000, w[i]});
      run({4'hB, sse_pkg::SUB_OP_LOW, k[i]});
      expect_rd("difference", sse_pkg::OFS_WORK, {24'h000000, r[i]});
      rdr(sse_pkg::OFS_STATUS);
      `CHK("arith flags", f[i], rd[3:0])
    end
  endtask : t_sub

  task automatic t_set();
    logic [7:0] a;
    for (int s = 0; s < 2; s++) begin
      a = s[0] ? 8'hA5 : 8'h5A;
      wr(sse_pkg::OFS_FADDR, {24'h000000, a});
      wr(sse_pkg::OFS_FDATA, 32'h000000DA);
      wr(sse_pkg::OFS_WORK, 32'h00000005);
      run({7'h15, s[0], a});
      expect_rd("file byte", sse_pkg::OFS_FDATA, 32'h000000FF);
      expect_rd("work", sse_pkg::OFS_WORK, s[0] ? 32'h00000005 : 32'h000000FF);
      rdr(sse_pkg::OFS_STATUS);
      `CHK("flags kept", 4'h9, rd[3:0])
    end
  endtask : t_set

  task automatic t_sleep();
    run(16'h0003);
    `CHK("status asleep", 8'h69, rd[7:0])
    `CHK("oscillator stopped", 1'b0, osc_run)
    rdr(sse_pkg::OFS_WDT);
    `CHK("watchdog count", 8'h00, rd[7:0])
    // cleared at sleep entry, four clocks of status polling since
    `CHK("postscaler fresh", 8'h04, rd[15:8])
    wr(sse_pkg::OFS_INSTR, 32'h00000003);
    `CHK("launch asleep", sse_pkg::RESP_SLVERR, rs)
    rdr(8'h18);
    `CHK("unmapped data", 32'h00000000, rd)
    `CHK("unmapped resp", sse_pkg::RESP_SLVERR, rs)
    wr(sse_pkg::OFS_WDT, 32'h00000001);
    rdr(sse_pkg::OFS_STATUS);
    `CHK("woken by write", 1'b0, rd[6])
    run(16'h0003);
    for (int i = 0; i < 60 && rd[6]; i++) rdr(sse_pkg::OFS_STATUS);
    `CHK("woken by watchdog", 3'h0, rd[6:4])
    `CHK("oscillator running", 1'b1, osc_run)
    run(16'h0002);
    `CHK("near sleep word", 1'b0, rd[6])
  endtask : t_sleep

  initial begin
    rst = 1'b1;
    s_awvalid = 1'b0;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h00000000;
    s_wstrb = 4'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    expect_rd("status at reset", sse_pkg::OFS_STATUS, 32'h00000030);
    expect_rd("work at reset", sse_pkg::OFS_WORK, 32'h00000000);
    t_busy();
    t_sub();
    t_set();
    t_sleep();
    stop_test();
  end
endmodule : sse_exec_tb
`default_nettype wire
